/* File: hw/lrr_pkg.sv */
// Purpose: shared constants for the literal-return and rotate execute block
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: opcode patterns are matched under masks
package lrr_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 9;
  localparam logic [11:0] RETLIT_MASK = 12'hf00;
  localparam logic [11:0] RETLIT_CODE = 12'h800;
  localparam logic [11:0] ROT_MASK = 12'hf80;
  localparam logic [11:0] ROTL_CODE = 12'h340;
  localparam logic [11:0] ROTR_CODE = 12'h300;
  localparam int DEST_BIT = 5;
  localparam int CARRY_BIT = 0;
  localparam int RETLIT_CYCLES = 2;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [1:0] FLUSH_CNT_INIT = 2'h1;
  typedef enum logic [1:0] {LRR_OP_NONE, LRR_OP_RETLIT, LRR_OP_ROTL, LRR_OP_ROTR} lrr_op_t;
endpackage

/* File: hw/lrr_rotator.sv */
// Purpose: one-bit rotate through carry, both directions
// Assumes: combinational, operand valid whenever used
// Notes: carry out is the bit shifted off the end
module lrr_rotator #(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W-1:0] operand_i,
  input wire logic carry_i,
  input wire logic left_i,
  output logic [DATA_W-1:0] result_o,
  output logic carry_o
);
  always_comb
  begin
    if (left_i)
    begin
      result_o = {operand_i[DATA_W-2:0], carry_i};
      carry_o = operand_i[DATA_W-1];
    end
    else
    begin
      result_o = {carry_i, operand_i[DATA_W-1:1]};
      carry_o = operand_i[0];
    end
  end
endmodule

/* File: hw/lrr_exec.sv */
// Purpose: decode and execute return-with-literal and the right rotate; ROTL_CODE never matches under ROT_MASK
// Assumes: file read data is combinational for FADDR_O in the same cycle
// Notes: return-with-literal flushes one fetched word after the jump

// Notes on behaviour
// - return_with_literal (1000 kkkk kkkk) loads literal into W, flags untouched.
// - return_with_literal loads PC from stack_top_entry.
// - return_with_literal is one word, two cycles; one empty cycle follows jump.
// - rotate_right_via_carry: old carry to bit 7, old bit 0 to carry.
// - destination bit 0 writes W, 1 writes back to the file register.
module lrr_exec #(
  parameter int PC_W = lrr_pkg::PC_W
) (
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic INSTR_VALID_I,
  input wire logic [11:0] INSTR_I,
  input wire logic [PC_W-1:0] STACK_TOP_ENTRY_I,
  input wire logic [7:0] FILE_RDATA_I,
  input wire logic CARRY_I,
  output logic [4:0] FADDR_O,
  output logic FILE_WE_O,
  output logic [7:0] FILE_WDATA_O,
  output logic [7:0] W_O,
  output logic CARRY_WE_O,
  output logic CARRY_O,
  output logic PC_LOAD_O,
  output logic [PC_W-1:0] PC_O,
  output logic STACK_POP_O,
  output logic FLUSH_O,
  output logic BUSY_O
);
  // first match wins; the three patterns never overlap
  function automatic lrr_pkg::lrr_op_t decode(input logic [11:0] ins);
    if ((ins & lrr_pkg::RETLIT_MASK) == lrr_pkg::RETLIT_CODE)
      return lrr_pkg::LRR_OP_RETLIT;
    else if ((ins & lrr_pkg::ROT_MASK) == lrr_pkg::ROTL_CODE)
      return lrr_pkg::LRR_OP_ROTL;
    else if ((ins & lrr_pkg::ROT_MASK) == lrr_pkg::ROTR_CODE)
      return lrr_pkg::LRR_OP_ROTR;
    else
      return lrr_pkg::LRR_OP_NONE;
  endfunction

  lrr_pkg::lrr_op_t op;
  logic flush_reg;
  logic accept;
  logic is_rot;
  logic dest_file;
  logic [7:0] rot_result;
  logic rot_carry;
  logic [7:0] w_reg;
  logic [7:0] w_next;
  logic carry_reg;
  logic carry_we_reg;
  logic [7:0] fwdata_reg;
  logic fwe_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_reg;

  // the word fetched behind the jump is discarded, never executed
  assign accept = INSTR_VALID_I && !flush_reg;
  assign op = accept ? decode(INSTR_I) : lrr_pkg::LRR_OP_NONE;
  assign is_rot = (op == lrr_pkg::LRR_OP_ROTL) || (op == lrr_pkg::LRR_OP_ROTR);
  assign dest_file = INSTR_I[lrr_pkg::DEST_BIT];
  assign FADDR_O = INSTR_I[4:0];

  // no carry forwarding: back-to-back rotates need status written first
  lrr_rotator #(
    .DATA_W(lrr_pkg::DATA_W)
  ) u_rot (
    .operand_i(FILE_RDATA_I),
    .carry_i(CARRY_I),
    .left_i(op == lrr_pkg::LRR_OP_ROTL),
    .result_o(rot_result),
    .carry_o(rot_carry)
  );

  always_comb
  begin
    // W moves only on a return or on a rotate that targets it
    w_next = w_reg;
    if (op == lrr_pkg::LRR_OP_RETLIT)
      w_next = INSTR_I[7:0];
    else if (is_rot && !dest_file)
      w_next = rot_result;
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      w_reg <= lrr_pkg::W_RESET;
    else
      w_reg <= w_next;
  end

  // file write-back, one cycle per rotate that targets the file
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      fwe_reg <= 1'b0;
      fwdata_reg <= 8'h00;
    end
    else
    begin
      fwe_reg <= is_rot && dest_file;
      if (is_rot && dest_file)
        fwdata_reg <= rot_result;
    end
  end

  // only rotates touch status, and only the carry bit
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      carry_we_reg <= 1'b0;
      carry_reg <= 1'b0;
    end
    else
    begin
      carry_we_reg <= is_rot;
      if (is_rot)
        carry_reg <= rot_carry;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pc_load_reg <= 1'b0;
      pc_reg <= '0;
    end
    else
    begin
      // address captured in the cycle the stack pops
      pc_load_reg <= op == lrr_pkg::LRR_OP_RETLIT;
      if (op == lrr_pkg::LRR_OP_RETLIT)
        pc_reg <= STACK_TOP_ENTRY_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      flush_reg <= 1'b0;
    else
      // a return offered in the bubble is refused, so no double pop
      flush_reg <= op == lrr_pkg::LRR_OP_RETLIT;
  end

  // pulse outputs are one cycle wide; the core must act on them at once
  assign W_O = w_reg;
  assign FILE_WE_O = fwe_reg;
  assign FILE_WDATA_O = fwdata_reg;
  assign CARRY_WE_O = carry_we_reg;
  assign CARRY_O = carry_reg;
  assign PC_LOAD_O = pc_load_reg;
  assign PC_O = pc_reg;
  assign STACK_POP_O = op == lrr_pkg::LRR_OP_RETLIT;
  assign FLUSH_O = flush_reg;
  assign BUSY_O = flush_reg;

  // checks run on the instruction clock and rest during reset
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);

  retlit_w_load_a: assert property (op == lrr_pkg::LRR_OP_RETLIT |=> W_O == $past(INSTR_I[7:0]))
    else $error("literal not loaded into W");
  retlit_no_flag_a: assert property (op == lrr_pkg::LRR_OP_RETLIT |=> !CARRY_WE_O)
    else $error("return changed a flag");
  retlit_pc_a: assert property (op == lrr_pkg::LRR_OP_RETLIT
      |=> PC_LOAD_O && PC_O == $past(STACK_TOP_ENTRY_I))
    else $error("pc not loaded from stack top");
  retlit_bubble_a: assert property (op == lrr_pkg::LRR_OP_RETLIT
      |=> FLUSH_O && op == lrr_pkg::LRR_OP_NONE ##1 !FLUSH_O)
    else $error("no single empty cycle after return");
  rotl_value_a: assert property (op == lrr_pkg::LRR_OP_ROTL
      |=> CARRY_WE_O && CARRY_O == $past(FILE_RDATA_I[7]))
    else $error("left rotate carry wrong");
  rotr_value_a: assert property (op == lrr_pkg::LRR_OP_ROTR && dest_file
      |=> FILE_WE_O && FILE_WDATA_O == {$past(CARRY_I), $past(FILE_RDATA_I[7:1])})
    else $error("right rotate result wrong");
  rot_dest_w_a: assert property (is_rot && !dest_file
      |=> !FILE_WE_O && W_O == ($past(op == lrr_pkg::LRR_OP_ROTL)
      ? {$past(FILE_RDATA_I[6:0]), $past(CARRY_I)}
      : {$past(CARRY_I), $past(FILE_RDATA_I[7:1])}))
    else $error("rotate to W misrouted");
  rot_single_a: assert property (is_rot |=> !FLUSH_O)
    else $error("rotate stalled the pipe");
  rotl_file_a: assert property (op == lrr_pkg::LRR_OP_ROTL && dest_file
      |=> FILE_WE_O && FILE_WDATA_O == {$past(FILE_RDATA_I[6:0]), $past(CARRY_I)})
    else $error("left rotate result wrong");
  rotr_carry_a: assert property (op == lrr_pkg::LRR_OP_ROTR
      |=> CARRY_WE_O && CARRY_O == $past(FILE_RDATA_I[0]))
    else $error("right rotate carry wrong");
  carry_hold_a: assert property (!is_rot |=> !CARRY_WE_O && $stable(CARRY_O))
    else $error("carry touched outside a rotate");
  retlit_no_write_a: assert property (op == lrr_pkg::LRR_OP_RETLIT |=> !FILE_WE_O)
    else $error("return wrote the file");
  w_hold_a: assert property (op == lrr_pkg::LRR_OP_NONE |=> $stable(W_O))
    else $error("W changed without a writer");
  pc_hold_a: assert property (op != lrr_pkg::LRR_OP_RETLIT
      |=> !PC_LOAD_O && $stable(PC_O))
    else $error("pc moved without a return");
  pop_decode_a: assert property (STACK_POP_O
      |-> INSTR_VALID_I && !FLUSH_O && INSTR_I[11:8] == 4'h8)
    else $error("stack popped without a return");
  // the word behind a jump must leave no trace, even a valid rotate
  bubble_refuse_a: assert property (FLUSH_O && INSTR_VALID_I
      |-> !STACK_POP_O ##1 !CARRY_WE_O && !FILE_WE_O && !PC_LOAD_O)
    else $error("word in the bubble took effect");

  cover_retlit_c: cover property (op == lrr_pkg::LRR_OP_RETLIT ##2 INSTR_VALID_I);
  cover_rotl_file_c: cover property (op == lrr_pkg::LRR_OP_ROTL && dest_file);
  cover_rotr_w_c: cover property (op == lrr_pkg::LRR_OP_ROTR && !dest_file);
  cover_rotl_w_c: cover property (op == lrr_pkg::LRR_OP_ROTL && !dest_file);
  cover_bubble_c: cover property (FLUSH_O && INSTR_VALID_I);
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the return and rotate execute block
// Assumes: bench models the status carry; one instruction per slot, then idle
// Notes: a rotate is offered in each bubble and must leave no trace
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic pl; logic fw; logic cw; logic [8:0] pc; logic [7:0] w;
    logic [7:0] wd; logic c;} lrr_exp_t;
  logic CLK_SYS_I = 1'b0;
  logic ARST_N_I = 1'b0;
  logic INSTR_VALID_I = 1'b0;
  logic [11:0] INSTR_I = 12'h000;
  logic [8:0] STACK_TOP_ENTRY_I = 9'h000;
  logic [7:0] FILE_RDATA_I = 8'h00;
  logic CARRY_I = 1'b0;
  logic [4:0] FADDR_O;
  logic FILE_WE_O, CARRY_WE_O, CARRY_O, PC_LOAD_O, STACK_POP_O, FLUSH_O, BUSY_O;
  logic [7:0] FILE_WDATA_O, W_O;
  logic [8:0] PC_O;
  int n_errors = 0;
  int checked = 0;
  int seed = 32'h624cdd3a;
  logic [7:0] w_m = 8'h00;
  logic c_m = 1'b0;
  lrr_exp_t q[$];
  lrr_exp_t m;
  logic [11:0] base[4] = '{12'h800, 12'h340, 12'h300, 12'h200};
  logic [11:0] msk[4] = '{12'h0ff, 12'h03f, 12'h03f, 12'h0ff};
  logic [31:0] r;
  always #5 CLK_SYS_I = ~CLK_SYS_I;
  lrr_exec DUT (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .INSTR_VALID_I(INSTR_VALID_I),
    .INSTR_I(INSTR_I), .STACK_TOP_ENTRY_I(STACK_TOP_ENTRY_I), .FILE_RDATA_I(FILE_RDATA_I),
    .CARRY_I(CARRY_I), .FADDR_O(FADDR_O), .FILE_WE_O(FILE_WE_O), .FILE_WDATA_O(FILE_WDATA_O),
    .W_O(W_O), .CARRY_WE_O(CARRY_WE_O), .CARRY_O(CARRY_O), .PC_LOAD_O(PC_LOAD_O),
    .PC_O(PC_O), .STACK_POP_O(STACK_POP_O), .FLUSH_O(FLUSH_O), .BUSY_O(BUSY_O));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // drives one word, notes the expected outcome, then offers a rotate in the bubble
  task automatic issue(input logic [11:0] ins);
    lrr_exp_t e;
    logic [7:0] f;
    logic [7:0] res;
    f = $random(seed);
    e = '{1'b0, 1'b0, 1'b0, 9'($random(seed)), w_m, 8'h00, c_m};
    res = 8'h00;
    @(posedge CLK_SYS_I);
    INSTR_I <= ins;
    INSTR_VALID_I <= 1'b1;
    FILE_RDATA_I <= f;
    CARRY_I <= c_m;
    STACK_TOP_ENTRY_I <= e.pc;
    if ((ins & 12'hf00) === 12'h800)
    begin
      e.pl = 1'b1;
      e.w = ins[7:0];
    end
    else if ((ins & 12'hf80) === 12'h340)
    begin
      e.cw = 1'b1;
      e.c = f[7];
      res = {f[6:0], c_m};
    end
    else if ((ins & 12'hf80) === 12'h300)
    begin
      e.cw = 1'b1;
      e.c = f[0];
      res = {c_m, f[7:1]};
    end
    if (e.cw && ins[5])
    begin
      e.fw = 1'b1;
      e.wd = res;
    end
    else if (e.cw)
      e.w = res;
    if (e.pl || e.cw)
      q.push_back(e);
    w_m = e.w;
    c_m = e.c;
    @(negedge CLK_SYS_I);
    chk("faddr", 9'(ins[4:0]), 9'(FADDR_O));
    chk("stack_pop", 9'(e.pl), 9'(STACK_POP_O));
    @(posedge CLK_SYS_I);
    INSTR_I <= 12'h37f;
    INSTR_VALID_I <= e.pl;
    @(posedge CLK_SYS_I);
    INSTR_VALID_I <= 1'b0;
  endtask
  // any pulse with nothing noted means a refused or unknown word took effect
  always @(negedge CLK_SYS_I)
    if (ARST_N_I && (PC_LOAD_O | CARRY_WE_O | FILE_WE_O | FLUSH_O) !== 1'b0)
    begin
      if (q.size() == 0)
      begin
        n_errors++;
        $display("mismatch pulse expected 0 seen 1");
      end
      else
      begin
        m = q.pop_front();
        chk("pc_load", 9'(m.pl), 9'(PC_LOAD_O));
        if (m.pl)
          chk("pc", m.pc, PC_O);
        chk("flush", 9'(m.pl), 9'(FLUSH_O));
        chk("busy", 9'(m.pl), 9'(BUSY_O));
        chk("w", 9'(m.w), 9'(W_O));
        chk("carry_we", 9'(m.cw), 9'(CARRY_WE_O));
        if (m.cw)
          chk("carry", 9'(m.c), 9'(CARRY_O));
        chk("file_we", 9'(m.fw), 9'(FILE_WE_O));
        if (m.fw)
          chk("wdata", 9'(m.wd), 9'(FILE_WDATA_O));
      end
    end
  initial
  begin
    repeat (10) @(posedge CLK_SYS_I);
    ARST_N_I <= 1'b1;
    issue(12'h8a5);
    issue(12'h37f);
    issue(12'h300);
    issue(12'h8ff);
    repeat (80)
    begin
      r = $random(seed);
      issue(base[r[13:12]] | (r[11:0] & msk[r[13:12]]));
    end
    repeat (3) @(posedge CLK_SYS_I);
    chk("left_in_queue", 9'h000, 9'(q.size()));
    final_report();
  end
  // about 265 cycles are needed; the limit leaves wide margin
  initial
  begin
    repeat (5000) @(posedge CLK_SYS_I);
    n_errors++;
    final_report();
  end
endmodule
